// file: verilog/prc_pkg.sv
// constants and carrier types for the ratio configuration block
// assumes a 250 MHz system clock and a serial front end that hands over
// decoded register writes and reads
// Behaviour
// - normal select: lock output high when locked
// - normal select: lock output low when unlocked
// - select code 11 forces lock output low
// - outputs run only while master pin high
// - clock outputs give K times 56 or 64 kHz; sync output gives a fixed 8 kHz
// - codes 0000/0001/0010 select T1-family combinations
// - codes 0100/0101/0110 select E1-family combinations
// - register 0 bit 0 enables first loop
// - register 1 bits 4..1 hold N minus one
// - register 1 bit 0 enables second loop
// - register 2 holds first K minus one
// - register 3 holds second K minus one
// - register 4 holds sync, pin enables, lock select
package prc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int            ADDR_W          = 3;
    localparam int            DATA_W          = 5;
    localparam logic [2:0]    ADDR_RATIO      = 3'h0;
    localparam logic [2:0]    ADDR_IN_MULT    = 3'h1;
    localparam logic [2:0]    ADDR_OUT1_MULT  = 3'h2;
    localparam logic [2:0]    ADDR_OUT2_MULT  = 3'h3;
    localparam logic [2:0]    ADDR_OUT_EN     = 3'h4;
    localparam logic [4:0]    REG_RESET       = 5'h00;

    // field positions
    localparam int            LOOP_EN_BIT     = 0;
    localparam int            SYNC_EN_BIT     = 4;
    localparam int            PIN1_EN_BIT     = 3;
    localparam int            PIN2_EN_BIT     = 2;
    localparam logic [1:0]    LOCK_SEL_FORCE  = 2'h3;

    // ratio codes in bits 4..1 of the ratio register
    localparam logic [3:0]    RC_T1_56_56     = 4'h0;
    localparam logic [3:0]    RC_T1_56_64     = 4'h1;
    localparam logic [3:0]    RC_T1_64_64     = 4'h2;
    localparam logic [3:0]    RC_E1_56_56     = 4'h4;
    localparam logic [3:0]    RC_E1_56_64     = 4'h5;
    localparam logic [3:0]    RC_E1_64_64     = 4'h6;

    // ****************************************
    // timing
    // ****************************************
    localparam longint        SYS_CLK_HZ      = 250_000_000;
    localparam longint        BASE_56_HZ      = 56_000;
    localparam longint        BASE_64_HZ      = 64_000;
    localparam longint        SYNC_HZ         = 8_000;
    localparam int            ACC_W           = 32;
    // phase step per unit of K, scaled to a 2^32 accumulator
    localparam logic [31:0]   STEP_56 =
        32'((BASE_56_HZ << ACC_W) / SYS_CLK_HZ);
    localparam logic [31:0]   STEP_64 =
        32'((BASE_64_HZ << ACC_W) / SYS_CLK_HZ);
    localparam logic [31:0]   STEP_SYNC =
        32'((SYNC_HZ << ACC_W) / SYS_CLK_HZ);

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [4:0] ratio;
        logic [4:0] in_mult;
        logic [4:0] out1_mult;
        logic [4:0] out2_mult;
        logic [4:0] out_en;
    } prc_cfg_t;

    typedef struct packed {
        logic       valid;
        logic       e1_family;
        logic       out1_is_64;
        logic       out2_is_64;
    } prc_ratio_t;

endpackage

// file: verilog/prc_nco.sv
// phase-accumulator clock source for one output
// assumes the step is stable or changes only between reconfigurations
module prc_nco
    import prc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        run_i,
    input  wire logic [31:0] step_i,
    output logic             clk_o
);

    logic [31:0] acc;
    logic [31:0] next_acc;
    logic        next_clk;

    always_comb
    begin
        // a stopped source restarts from zero phase, low
        next_acc = run_i ? acc + step_i : 32'h00000000;
        next_clk = run_i & next_acc[ACC_W-1];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            acc   <= 32'h00000000;
            clk_o <= 1'b0;
        end
        else if (ce_i)
        begin
            acc   <= next_acc;
            clk_o <= next_clk;
        end
    end

endmodule

// file: verilog/prc_ratio_cfg.sv
// command registers and forward master mode output control
// assumes the serial front end delivers one-cycle write strobes and
// that the loop lock and master select arrive as asynchronous pins
module prc_ratio_cfg
    import prc_pkg::*;
(
    input  wire logic              SYS_CLK_I,
    input  wire logic              NRST_I,
    input  wire logic              CE_I,
    input  wire logic              REG_WR_I,
    input  wire logic              REG_RD_I,
    input  wire logic [ADDR_W-1:0] REG_ADDR_I,
    input  wire logic [DATA_W-1:0] REG_WDATA_I,
    output logic      [DATA_W-1:0] REG_RDATA_O,
    input  wire logic              MASTER_SEL_I,
    input  wire logic              FIRST_LOOP_LOCK_I,
    output logic                   FIRST_CLOCK_OUT_O,
    output logic                   SECOND_CLOCK_OUT_O,
    output logic                   SYNC_OUT_O,
    output logic                   LOCK_INDICATOR_OUT_O
);

    // ****************************************
    // ratio code decode
    // ****************************************
    function automatic prc_ratio_t decode_ratio(input logic [3:0] code);
        prc_ratio_t r;
        r = '0;
        case (code)
            RC_T1_56_56: r = '{1'b1, 1'b0, 1'b0, 1'b0};
            RC_T1_56_64: r = '{1'b1, 1'b0, 1'b0, 1'b1};
            RC_T1_64_64: r = '{1'b1, 1'b0, 1'b1, 1'b1};
            RC_E1_56_56: r = '{1'b1, 1'b1, 1'b0, 1'b0};
            RC_E1_56_64: r = '{1'b1, 1'b1, 1'b0, 1'b1};
            RC_E1_64_64: r = '{1'b1, 1'b1, 1'b1, 1'b1};
            // other codes belong to modes this block does not serve
            default:     r = '0;
        endcase
        return r;
    endfunction

    // K field to phase step: (field + 1) units of the base rate
    function automatic logic [31:0] out_step(input logic [4:0] kfield,
                                             input logic       is_64);
        logic [31:0] k;
        k = {27'h0000000, kfield} + 32'h00000001;
        return 32'(k * (is_64 ? STEP_64 : STEP_56));
    endfunction

    // one-hot register select; addresses 5..7 hit nothing
    function automatic logic [4:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [4:0] s;
        s = 5'h00;
        case (a)
            ADDR_RATIO:     s = 5'h01;
            ADDR_IN_MULT:   s = 5'h02;
            ADDR_OUT1_MULT: s = 5'h04;
            ADDR_OUT2_MULT: s = 5'h08;
            ADDR_OUT_EN:    s = 5'h10;
            default:        s = 5'h00;
        endcase
        return s;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] master_sync;
    logic [1:0] lock_sync;
    logic [1:0] next_master_sync;
    logic [1:0] next_lock_sync;

    always_comb
    begin
        // only the second stage feeds logic; the first may be metastable
        next_master_sync = {master_sync[0], MASTER_SEL_I};
        next_lock_sync   = {lock_sync[0], FIRST_LOOP_LOCK_I};
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
        begin
            master_sync <= 2'h0;
            lock_sync   <= 2'h0;
        end
        else if (CE_I)
        begin
            master_sync <= next_master_sync;
            lock_sync   <= next_lock_sync;
        end
    end

    // ****************************************
    // command registers
    // ****************************************
    prc_cfg_t          cfg;
    prc_cfg_t          next_cfg;
    logic [DATA_W-1:0] next_rdata;
    logic [4:0]        wr_hit;
    logic [4:0]        rd_hit;

    always_comb
    begin
        next_cfg   = cfg;
        next_rdata = REG_RDATA_O;
        wr_hit     = REG_WR_I ? reg_sel(REG_ADDR_I) : 5'h00;
        rd_hit     = reg_sel(REG_ADDR_I);
        // writes land directly, no separate commit step
        if (wr_hit[0])
            next_cfg.ratio     = REG_WDATA_I;
        if (wr_hit[1])
            next_cfg.in_mult   = REG_WDATA_I;
        if (wr_hit[2])
            next_cfg.out1_mult = REG_WDATA_I;
        if (wr_hit[3])
            next_cfg.out2_mult = REG_WDATA_I;
        if (wr_hit[4])
            next_cfg.out_en    = REG_WDATA_I;
        // a read beside a write in one cycle returns the old value
        if (REG_RD_I)
        begin
            next_rdata = 5'h00;
            if (rd_hit[0])
                next_rdata = cfg.ratio;
            if (rd_hit[1])
                next_rdata = cfg.in_mult;
            if (rd_hit[2])
                next_rdata = cfg.out1_mult;
            if (rd_hit[3])
                next_rdata = cfg.out2_mult;
            if (rd_hit[4])
                next_rdata = cfg.out_en;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
        begin
            cfg         <= '{REG_RESET, REG_RESET, REG_RESET,
                             REG_RESET, REG_RESET};
            REG_RDATA_O <= 5'h00;
        end
        else if (CE_I)
        begin
            cfg         <= next_cfg;
            REG_RDATA_O <= next_rdata;
        end
    end

    // ****************************************
    // output control
    // ****************************************
    prc_ratio_t  rc;
    logic        master;
    logic [2:0]  run;
    logic [31:0] step [3];
    logic [2:0]  clk_gen;

    always_comb
    begin
        rc     = decode_ratio(cfg.ratio[4:1]);
        master = master_sync[1];
        // the reference multiple does not shape the outputs here:
        // the loop divides the reference by N before comparison
        run[0] = master & rc.valid & cfg.ratio[LOOP_EN_BIT]
                 & cfg.out_en[PIN1_EN_BIT];
        run[1] = master & rc.valid & cfg.in_mult[LOOP_EN_BIT]
                 & cfg.out_en[PIN2_EN_BIT];
        run[2] = master & rc.valid & cfg.out_en[SYNC_EN_BIT];
        step[0] = out_step(cfg.out1_mult, rc.out1_is_64);
        step[1] = out_step(cfg.out2_mult, rc.out2_is_64);
        step[2] = STEP_SYNC;
    end

    // ****************************************
    // lock indicator
    // ****************************************
    logic next_lock_ind;

    always_comb
    begin
        // select codes 00, 01 and 10 all mean normal indication
        if (cfg.out_en[1:0] == LOCK_SEL_FORCE)
            next_lock_ind = 1'b0;
        else
            next_lock_ind = lock_sync[1];
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
            LOCK_INDICATOR_OUT_O <= 1'b0;
        else if (CE_I)
            LOCK_INDICATOR_OUT_O <= next_lock_ind;
    end

    // ****************************************
    // clock sources
    // ****************************************
    // two outputs and the sync share one accumulator design
    for (genvar g = 0; g < 3; g++)
    begin : gen_src
        prc_nco u_nco (
            .clk_i   (SYS_CLK_I),
            .rst_n_i (NRST_I),
            .ce_i    (CE_I),
            .run_i   (run[g]),
            .step_i  (step[g]),
            .clk_o   (clk_gen[g])
        );
    end

    always_comb
    begin
        FIRST_CLOCK_OUT_O  = clk_gen[0];
        SECOND_CLOCK_OUT_O = clk_gen[1];
        SYNC_OUT_O         = clk_gen[2];
    end

endmodule

// file: dv/prc_ratio_cfg_monitor.sv
// port checker for the ratio configuration block
// assumes CE_I drops only briefly, with the pins steady meanwhile
module prc_ratio_cfg_monitor
    import prc_pkg::*;
(
    input wire logic              SYS_CLK_I,
    input wire logic              NRST_I,
    input wire logic              CE_I,
    input wire logic              REG_WR_I,
    input wire logic              REG_RD_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic [DATA_W-1:0] REG_RDATA_O,
    input wire logic              MASTER_SEL_I,
    input wire logic              FIRST_LOOP_LOCK_I,
    input wire logic              FIRST_CLOCK_OUT_O,
    input wire logic              SECOND_CLOCK_OUT_O,
    input wire logic              SYNC_OUT_O,
    input wire logic              LOCK_INDICATOR_OUT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // register shadow
    // ****************
    logic [4:0] sh [5];
    logic [4:0] exp_rd;
    logic       ok;
    logic [1:0] sel;
    assign ok  = sh[0][4:1] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
    assign sel = sh[4][1:0];
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!NRST_I)
        begin
            sh     <= '{default: 5'h00};
            exp_rd <= 5'h00;
        end
        else if (CE_I)
        begin
            if (REG_WR_I && REG_ADDR_I < 3'h5)
                sh[REG_ADDR_I] <= REG_WDATA_I;
            if (REG_RD_I)
                exp_rd <= (REG_ADDR_I < 3'h5) ? sh[REG_ADDR_I] : 5'h00;
        end
    end
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);
    // margins cover the two-flop pin sync plus output register
    AST_LOCK_HIGH: assert property (
        (FIRST_LOOP_LOCK_I && sel != 2'h3)[*4] |=> LOCK_INDICATOR_OUT_O)
        else $error("lock output not high");
    AST_LOCK_LOW: assert property (
        (!FIRST_LOOP_LOCK_I)[*4] |=> !LOCK_INDICATOR_OUT_O)
        else $error("lock output not low");
    AST_LOCK_FORCE: assert property (
        (sel == 2'h3)[*3] |=> !LOCK_INDICATOR_OUT_O)
        else $error("forced lock output not low");
    AST_READ: assert property (
        CE_I && REG_RD_I |=> REG_RDATA_O == exp_rd)
        else $error("read data wrong");
    AST_RD_HOLD: assert property (
        !(CE_I && REG_RD_I) |=> $stable(REG_RDATA_O))
        else $error("read data moved");
    AST_NO_MASTER: assert property (
        (!MASTER_SEL_I)[*6] |=> !(FIRST_CLOCK_OUT_O || SECOND_CLOCK_OUT_O))
        else $error("clock out without master");
    AST_OUT1_OFF: assert property (
        (!(ok && sh[0][0] && sh[4][3]))[*6] |=> !FIRST_CLOCK_OUT_O)
        else $error("first clock not held");
    AST_OUT2_OFF: assert property (
        (!(ok && sh[1][0] && sh[4][2]))[*6] |=> !SECOND_CLOCK_OUT_O)
        else $error("second clock not held");
endmodule
bind prc_ratio_cfg prc_ratio_cfg_monitor prc_ratio_cfg_monitor_inst (.*);

// file: dv/prc_loop_model.sv
// loop lock and master pin source for the bench
// assumes the block's clock drives it
module prc_loop_model #(
    parameter int ACQ = 20
)(
    input  wire logic clk_i,
    input  wire logic run_i,
    input  wire logic master_i,
    output logic      master_o,
    output logic      lock_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial
    begin
        lock_o   = 1'b0;
        master_o = 1'b1;
    end
    // lock comes slowly and drops at once, as a real loop does
    always @(posedge clk_i)
    begin
        cnt      <= run_i ? (cnt < ACQ ? cnt + 1 : cnt) : 0;
        lock_o   <= run_i && cnt >= ACQ;
        master_o <= master_i;
    end
endmodule

// file: dv/test_prc_ratio_cfg.sv
// self-checking bench for the ratio configuration block
// assumes prc_pkg, the loop model and the checker compiled first
module test_prc_ratio_cfg;
    timeunit 1ns;
    timeprecision 1ps;
    import prc_pkg::*;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              master = 1'b1;
    logic              ce = 1'b1;
    logic              run = 1'b0;
    logic [ADDR_W-1:0] addr = 3'h0;
    logic [DATA_W-1:0] wdata = 5'h00;
    logic [DATA_W-1:0] rdata;
    logic              mpin, lock, out1, out2, sync, lock_out;
    int                fail_count = 0;
    int                cmp_count = 0;
    prc_loop_model prc_loop_model_inst (.clk_i(clk), .run_i(run),
        .master_i(master), .master_o(mpin), .lock_o(lock));
    prc_ratio_cfg prc_ratio_cfg_inst (.SYS_CLK_I(clk), .NRST_I(nrst),
        .CE_I(ce), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .MASTER_SEL_I(mpin),
        .FIRST_LOOP_LOCK_I(lock), .FIRST_CLOCK_OUT_O(out1),
        .SECOND_CLOCK_OUT_O(out2), .SYNC_OUT_O(sync),
        .LOCK_INDICATOR_OUT_O(lock_out));
    initial forever #2 clk = ~clk;
    // ****************
    // helpers
    // ****************
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s, int t = 0);
        cmp_count++;
        if (t == 0 ? s !== e : (s > e + t || s + t < e))
        begin
            $display("CHECK FAILED %s exp %0d got %0d", nm, e, s);
            fail_count++;
        end
    endtask
    task automatic reg_wr(logic [2:0] a, logic [4:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [2:0] a, output logic [4:0] d);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask
    // cycles between two rising edges of one output
    task automatic period(int w, output int p);
        logic pv, cv;
        int e0;
        e0 = -1; p = -1; pv = 1'b1;
        for (int n = 0; n < 50000; n++)
        begin
            @(posedge clk);
            #1 cv = (w == 0) ? out1 : (w == 1) ? out2 : sync;
            if (cv === 1'b1 && pv === 1'b0)
            begin
                if (e0 >= 0) begin p = n - e0; break; end
                e0 = n;
            end
            pv = cv;
        end
    endtask
    task automatic quiet(string nm);
        int h;
        h = 0;
        repeat (10) @(posedge clk);
        repeat (300)
        begin
            @(posedge clk);
            #1 if (out1 !== 1'b0 || out2 !== 1'b0 || sync !== 1'b0) h++;
        end
        chk(nm, 0, h);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_regs;
        logic [4:0] d;
        for (int i = 0; i < 6; i++)
        begin
            reg_rd(3'(i), d);
            chk("rst", 0, d);
        end
        for (int i = 0; i < 6; i++) reg_wr(3'(i), 5'h1F - 5'(i));
        for (int i = 0; i < 6; i++)
        begin
            reg_rd(3'(i), d);
            chk("reg", i < 5 ? 5'h1F - 5'(i) : 5'h00, d);
        end
        // a write while the clock enable is low must not land
        @(posedge clk) ce <= 1'b0;
        reg_wr(3'h2, 5'h00);
        @(posedge clk) ce <= 1'b1;
        reg_rd(3'h2, d);
        chk("ce_frozen", 5'h1D, d);
    endtask
    task automatic t_sync;
        int p;
        reg_wr(ADDR_RATIO, {RC_T1_56_56, 1'b1});
        reg_wr(ADDR_OUT_EN, 5'h10);
        period(2, p);
        chk("sync_per", 32'(SYS_CLK_HZ / SYNC_HZ), p, 2);
    endtask
    task automatic t_lock;
        for (int s = 0; s < 4; s++)
        begin
            reg_wr(3'h4, 5'(s));
            @(posedge clk) run <= 1'b1;
            repeat (30) @(posedge clk);
            #1 chk("lock_on", s != 3, lock_out);
            @(posedge clk) run <= 1'b0;
            repeat (8) @(posedge clk);
            #1 chk("lock_off", 0, lock_out);
        end
    endtask
    task automatic t_freq;
        logic [3:0] c [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
        int p;
        reg_wr(3'h2, 5'h1F);
        reg_wr(3'h3, 5'h0F);
        reg_wr(3'h1, 5'h01);
        reg_wr(3'h4, 5'h0C);
        foreach (c[i])
        begin
            reg_wr(3'h0, {c[i], 1'b1});
            period(0, p);
            chk("per1", 250000 / (32 * (c[i][1] ? 64 : 56)), p, 2);
            period(1, p);
            chk("per2", 250000 / (16 * (c[i][1:0] != 0 ? 64 : 56)), p, 2);
        end
        reg_wr(3'h4, 5'h00);
        quiet("pins_off");
        reg_wr(3'h4, 5'h1C);
        reg_wr(3'h0, 5'h07);
        quiet("bad_code");
        reg_wr(3'h0, 5'h05);
        @(posedge clk) master <= 1'b0;
        quiet("slave");
    endtask
    task automatic print_verdict;
        $display("mismatches %0d of %0d checks", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_lock();
        t_sync();
        t_freq();
        print_verdict();
    end
    initial
    begin
        repeat (80000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
endmodule
